//--- include/pmx_pkg.sv
`default_nettype none
package pmx_pkg;
  // ****************************************
  // port 0 interface modes
  // ****************************************
  typedef enum logic [1:0] {
    PMX_MII_MAC,
    PMX_MII_PHY,
    PMX_RMII_MAC,
    PMX_RMII_PHY
  } pmx_mode_e;

  // management role
  typedef enum logic {
    PMX_MGMT_SLAVE,
    PMX_MGMT_MASTER
  } pmx_mgmt_e;

  // ****************************************
  // register map, word addresses on the plain port
  // ****************************************
  localparam int          PMX_ADDR_W         = 4;
  localparam int          PMX_DATA_W         = 32;
  localparam logic [3:0]  PMX_REG_BASIC      = 4'h0;
  localparam logic [3:0]  PMX_REG_SPECIAL    = 4'h1;
  localparam logic [3:0]  PMX_REG_STATUS     = 4'h2;
  localparam logic [3:0]  PMX_REG_MGMT       = 4'h3;

  // basic control fields
  localparam int          PMX_BASIC_ISO_BIT  = 10;
  // special control fields
  localparam int          PMX_SPEC_DIR_BIT   = 0;
  localparam int          PMX_SPEC_STR_BIT   = 1;
  // management register fields
  localparam int          PMX_MGMT_OUT_BIT   = 0;
  localparam int          PMX_MGMT_OE_BIT    = 1;
  localparam int          PMX_MGMT_MDC_BIT   = 2;

  // reset values
  localparam logic [31:0] PMX_BASIC_RST      = 32'h0000_0000;
  localparam logic [31:0] PMX_SPECIAL_RST    = 32'h0000_0000;
  localparam logic [31:0] PMX_MGMT_RST       = 32'h0000_0000;

  // ****************************************
  // timing
  // ****************************************
  localparam int          PMX_MCLK_MHZ       = 200;
  localparam int          PMX_REFCLK_MHZ     = 50;
  // half period of the generated reference clock in mclk cycles
  localparam int          PMX_REF_HALF       = PMX_MCLK_MHZ / (2 * PMX_REFCLK_MHZ);
  localparam int          PMX_SYNC_STAGES    = 2;

  // pad control bundle for one pin
  typedef struct packed {
    logic outEnN;   // low while driving
    logic inBufEn;
    logic pullDnEn;
    logic strongDrv;
  } pmx_pad_s;
endpackage
`default_nettype wire

//--- src/pmx_sync.sv
`default_nettype none
module pmx_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             resetn,
  input  wire logic             clkEn,
  // data
  input  wire logic [WIDTH-1:0] asyncIn,
  output var  logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] meta_q;

  // ****************************************
  // two-flop synchroniser
  // ****************************************
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      meta_q  <= '0;
      syncOut <= '0;
    end else if (clkEn) begin
      meta_q  <= asyncIn;
      syncOut <= meta_q;
    end
  end
endmodule // pmx_sync
`default_nettype wire

//--- src/pmx_clkgen.sv
`default_nettype none
module pmx_clkgen #(
  parameter int HALF = 2
) (
  // clock and reset
  input  wire logic mclk,
  input  wire logic resetn,
  input  wire logic clkEn,
  // control
  input  wire logic run,
  output var  logic clkOut
);
  logic [7:0] cnt_q;

  // ****************************************
  // divider, holds low when not running
  // ****************************************
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cnt_q  <= 8'h00;
      clkOut <= 1'b0;
    end else if (clkEn) begin
      if (!run) begin
        cnt_q  <= 8'h00;
        clkOut <= 1'b0;
      end else if (cnt_q == 8'(HALF - 1)) begin
        cnt_q  <= 8'h00;
        clkOut <= ~clkOut;
      end else begin
        cnt_q  <= cnt_q + 8'h01;
      end
    end
  end
endmodule // pmx_clkgen
`default_nettype wire

//--- src/pmx_port0_pin_ctrl.sv
`default_nettype none
module pmx_port0_pin_ctrl
  import pmx_pkg::*;
#(
  parameter int REF_HALF = PMX_REF_HALF
) (
  // clock and reset
  input  wire logic                    mclk,
  input  wire logic                    resetn,
  input  wire logic                    clkEn,
  // straps
  input  wire logic                    port0_mode_strap_bit0,
  input  wire logic                    modeStrapBit1,
  input  wire logic                    mgmtStrap,
  // register port
  input  wire logic [PMX_ADDR_W-1:0]   regAddr,
  input  wire logic [PMX_DATA_W-1:0]   regWdata,
  input  wire logic                    regWr,
  input  wire logic                    regRd,
  output var  logic [PMX_DATA_W-1:0]   regRdata,
  // reference clock pin
  input  wire logic                    refClkIn,
  output var  logic                    refClkOut,
  output var  pmx_pkg::pmx_pad_s       refClkPad,
  // collision and carrier sense pins
  input  wire logic                    colIn,
  output var  logic                    colOut,
  output var  logic                    colOeN,
  input  wire logic                    crsIn,
  output var  logic                    crsOut,
  output var  logic                    crsOeN,
  // internal collision and carrier events
  input  wire logic                    coreCol,
  input  wire logic                    coreCrs,
  output var  logic                    seenCol,
  output var  logic                    seenCrs,
  // management pins
  input  wire logic                    mdioIn,
  output var  logic                    mdioOut,
  output var  logic                    mdioOeN,
  input  wire logic                    mdcIn,
  output var  logic                    mdcOut,
  output var  logic                    mdcOeN,
  // slave side management to core
  input  wire logic                    slvMdioOut,
  input  wire logic                    slvMdioOe,
  output var  logic                    slvMdio,
  output var  logic                    slvMdcRise
);
  import pmx_pkg::*;

  // ****************************************
  // state
  // ****************************************
  pmx_mode_e              mode_q;
  pmx_mgmt_e              mgmt_q;
  logic                   strapDone_q;
  logic [PMX_DATA_W-1:0]  basic_q;
  logic [PMX_DATA_W-1:0]  special_q;
  logic [PMX_DATA_W-1:0]  mgmtReg_q;
  logic [PMX_DATA_W-1:0]  rdata_d;
  logic [2:0]             strapSync;
  logic [3:0]             pinSync;
  logic                   refSync;
  logic                   mdcSync_q;
  logic                   genClk;
  logic                   isRmii;
  logic                   isoBit;
  logic                   dirOut;
  logic                   phyMode;

  function automatic logic rmiiMode(input pmx_mode_e m);
    return (m == PMX_RMII_MAC) || (m == PMX_RMII_PHY);
  endfunction

  // ****************************************
  // pin synchronisers
  // ****************************************
  pmx_sync #(
    .WIDTH (3)
  ) u_strapSync (
    .mclk    (mclk),
    .resetn  (1'b1),    // keeps tracking through reset, settled at release
    .clkEn   (clkEn),
    .asyncIn ({mgmtStrap, modeStrapBit1, port0_mode_strap_bit0}),
    .syncOut (strapSync)
  );

  pmx_sync #(
    .WIDTH (4)
  ) u_pinSync (
    .mclk    (mclk),
    .resetn  (resetn),
    .clkEn   (clkEn),
    .asyncIn ({mdioIn, mdcIn, crsIn, colIn}),
    .syncOut (pinSync)
  );

  pmx_sync #(
    .WIDTH (1)
  ) u_refSync (
    .mclk    (mclk),
    .resetn  (resetn),
    .clkEn   (clkEn),
    .asyncIn (refClkIn),
    .syncOut (refSync)
  );

  // ****************************************
  // strap capture after reset release
  // ****************************************
  // mode from strap
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      mode_q      <= PMX_MII_MAC;
      mgmt_q      <= PMX_MGMT_SLAVE;
      strapDone_q <= 1'b0;
    end else if (clkEn && !strapDone_q) begin
      mode_q      <= pmx_mode_e'(strapSync[1:0]);
      mgmt_q      <= pmx_mgmt_e'(strapSync[2]);
      strapDone_q <= 1'b1;
    end
  end

  // ****************************************
  // register writes
  // ****************************************
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      basic_q   <= PMX_BASIC_RST;
      special_q <= PMX_SPECIAL_RST;
      mgmtReg_q <= PMX_MGMT_RST;
    end else if (clkEn && regWr) begin
      if (regAddr == PMX_REG_BASIC) begin
        basic_q <= regWdata;
      end else if (regAddr == PMX_REG_SPECIAL) begin
        special_q <= regWdata;
      end else if (regAddr == PMX_REG_MGMT) begin
        mgmtReg_q <= regWdata;
      end
    end
  end

  // read mux, unmapped reads zero
  always_comb begin
    rdata_d = '0;
    if (regAddr == PMX_REG_BASIC) begin
      rdata_d = basic_q;
    end else if (regAddr == PMX_REG_SPECIAL) begin
      rdata_d = special_q;
    end else if (regAddr == PMX_REG_STATUS) begin
      rdata_d = {24'h000000, strapDone_q, mgmt_q, mode_q, seenCrs, seenCol, 2'b00};
    end else if (regAddr == PMX_REG_MGMT) begin
      rdata_d = mgmtReg_q;
    end
  end

  // read data the cycle after the strobe only
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      regRdata <= '0;
    end else if (clkEn) begin
      regRdata <= regRd ? rdata_d : '0;
    end
  end

  // ****************************************
  // reference clock pad
  // ****************************************
  assign isRmii  = rmiiMode(mode_q);
  assign isoBit  = basic_q[PMX_BASIC_ISO_BIT];
  assign dirOut  = special_q[PMX_SPEC_DIR_BIT];
  assign phyMode = (mode_q == PMX_MII_PHY);

  pmx_clkgen #(
    .HALF (REF_HALF)
  ) u_refGen (
    .mclk   (mclk),
    .resetn (resetn),
    .clkEn  (clkEn),
    .run    (isRmii && dirOut),
    .clkOut (genClk)
  );

  // pad control registered from mode and control bits
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      refClkPad <= '{outEnN: 1'b1, inBufEn: 1'b0, pullDnEn: 1'b1, strongDrv: 1'b0};
      refClkOut <= 1'b0;
    end else if (clkEn) begin
      refClkOut           <= genClk;
      refClkPad.strongDrv <= special_q[PMX_SPEC_STR_BIT];
      if (mode_q == PMX_RMII_PHY && isoBit) begin
        refClkPad.outEnN   <= 1'b1;
        refClkPad.inBufEn  <= 1'b0;
        refClkPad.pullDnEn <= 1'b0;
      end else if (isRmii && dirOut) begin
        refClkPad.outEnN   <= 1'b0;
        refClkPad.inBufEn  <= 1'b0;
        refClkPad.pullDnEn <= 1'b0;
      end else begin
        refClkPad.outEnN   <= 1'b1;
        refClkPad.inBufEn  <= isRmii;
        refClkPad.pullDnEn <= 1'b1;
      end
    end
  end

  // ****************************************
  // collision and carrier sense
  // ****************************************
  // collision and carrier out in mii phy mode, isolate off
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      colOut <= 1'b0;
      crsOut <= 1'b0;
      colOeN <= 1'b1;
      crsOeN <= 1'b1;
    end else if (clkEn) begin
      colOut <= phyMode && coreCol;
      crsOut <= phyMode && coreCrs;
      colOeN <= !(phyMode && !isoBit);
      crsOeN <= !(phyMode && !isoBit);
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      seenCol <= 1'b0;
      seenCrs <= 1'b0;
    end else if (clkEn) begin
      seenCol <= (mode_q == PMX_MII_MAC) && pinSync[0];
      seenCrs <= (mode_q == PMX_MII_MAC) && pinSync[1];
    end
  end

  // ****************************************
  // management pins
  // ****************************************
  // data line, driven from the register in master, from the slave core otherwise
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      mdioOut <= 1'b1;
      mdioOeN <= 1'b1;
      slvMdio <= 1'b1;
    end else if (clkEn) begin
      slvMdio <= pinSync[3];
      if (mgmt_q == PMX_MGMT_MASTER) begin
        mdioOut <= mgmtReg_q[PMX_MGMT_OUT_BIT];
        mdioOeN <= !mgmtReg_q[PMX_MGMT_OE_BIT];
      end else begin
        mdioOut <= slvMdioOut;
        mdioOeN <= !slvMdioOe;
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      mdcOut     <= 1'b0;
      mdcOeN     <= 1'b1;
      mdcSync_q  <= 1'b0;
      slvMdcRise <= 1'b0;
    end else if (clkEn) begin
      mdcSync_q  <= pinSync[2];
      slvMdcRise <= (mgmt_q == PMX_MGMT_SLAVE) && pinSync[2] && !mdcSync_q;
      mdcOut     <= (mgmt_q == PMX_MGMT_MASTER) && mgmtReg_q[PMX_MGMT_MDC_BIT];
      mdcOeN     <= (mgmt_q != PMX_MGMT_MASTER);
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  sequence isoPhy_s;
    clkEn && mode_q == PMX_RMII_PHY && isoBit;
  endsequence

  isolate_pad_a: assert property (@(posedge mclk) disable iff (!resetn)
    isoPhy_s ##1 clkEn |-> refClkPad.outEnN && !refClkPad.inBufEn && !refClkPad.pullDnEn)
    else $error("isolated reference clock pad still active");

  refclk_out_a: assert property (@(posedge mclk) disable iff (!resetn)
    (clkEn && isRmii && dirOut && !(mode_q == PMX_RMII_PHY && isoBit)) ##1 clkEn |-> !refClkPad.outEnN)
    else $error("reference clock not driven");

  refclk_in_a: assert property (@(posedge mclk) disable iff (!resetn)
    (clkEn && !dirOut) ##1 clkEn |-> refClkPad.outEnN)
    else $error("reference clock driven while input");

  refclk_buf_a: assert property (@(posedge mclk) disable iff (!resetn)
    !refClkPad.outEnN |-> !refClkPad.inBufEn && !refClkPad.pullDnEn)
    else $error("buffer or pull active while driving");

  drive_str_a: assert property (@(posedge mclk) disable iff (!resetn)
    clkEn ##1 clkEn |-> refClkPad.strongDrv == $past(special_q[PMX_SPEC_STR_BIT]))
    else $error("drive strength mismatch");

  col_drive_a: assert property (@(posedge mclk) disable iff (!resetn)
    (clkEn && phyMode) ##1 clkEn |-> colOeN == $past(isoBit))
    else $error("collision driver state wrong");

  crs_drive_a: assert property (@(posedge mclk) disable iff (!resetn)
    (clkEn && !phyMode) ##1 clkEn |-> crsOeN && !crsOut)
    else $error("carrier driven outside phy mode");

  rmii_ignore_a: assert property (@(posedge mclk) disable iff (!resetn)
    (clkEn && isRmii) ##1 clkEn |-> !seenCol && !seenCrs)
    else $error("rmii reacted to collision or carrier");

  mdc_dir_a: assert property (@(posedge mclk) disable iff (!resetn)
    (clkEn && mgmt_q == PMX_MGMT_MASTER) ##1 clkEn |-> !mdcOeN)
    else $error("management clock not driven in master");

  strap_hold_a: assert property (@(posedge mclk) disable iff (!resetn)
    strapDone_q ##1 1'b1 |-> $stable(mode_q) && $stable(mgmt_q))
    else $error("strap value changed after capture");

  mdio_idle_a: assert property (@(posedge mclk) disable iff (!resetn)
    (clkEn && ((mgmt_q == PMX_MGMT_MASTER) ? !mgmtReg_q[PMX_MGMT_OE_BIT] : !slvMdioOe)) ##1 clkEn |-> mdioOeN)
    else $error("management data line not released");
endmodule // pmx_port0_pin_ctrl
`default_nettype wire

//--- dv/pmx_far_end.sv
`default_nettype none
// far side: external mac or phy and the management master
module pmx_far_end (
  // device pin drives
  input  wire logic              mdioOut,
  input  wire logic              mdioOeN,
  input  wire logic              mdcOut,
  input  wire logic              mdcOeN,
  input  wire logic              refClkOut,
  input  wire pmx_pkg::pmx_pad_s refClkPad,
  // resolved pin levels
  output var  logic              refClkIn,
  output var  logic              colIn,
  output var  logic              crsIn,
  output var  logic              mdioIn,
  output var  logic              mdcIn
);
  timeunit 1ns;
  timeprecision 100ps;
  import pmx_pkg::*;
  logic refGen  = 1'b0;
  logic mdcDrv  = 1'b0;
  logic mdioDrv = 1'b0;
  logic mdioEn  = 1'b0;
  initial begin
    colIn = 1'b0;
    crsIn = 1'b0;
  end
  always #10 refGen = ~refGen;
  assign refClkIn = !refClkPad.outEnN ? refClkOut : refGen;
  assign mdioIn = ((!mdioOeN && !mdioOut) || (mdioEn && !mdioDrv)) ? 1'b0 : 1'b1;
  // clock from whoever drives, pull-down idle
  assign mdcIn = !mdcOeN ? mdcOut : mdcDrv;
  task automatic set_line(input logic col, input logic crs);
    colIn = col;
    crsIn = crs;
  endtask
  // one frame, clock still outside it
  task automatic frame(input int bits);
    for (int i = 0; i < bits; i++) begin
      mdioEn = (i < bits / 2);
      mdioDrv = 1'($urandom);
      #80 mdcDrv = 1'b1;
      #80 mdcDrv = 1'b0;
    end
    mdioEn = 1'b0;
  endtask
endmodule // pmx_far_end
`default_nettype wire

//--- dv/pmx_port0_pin_ctrl_bench.sv
`default_nettype none
module pmx_port0_pin_ctrl_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import pmx_pkg::*;
  localparam int HALF = 2;
  logic                  mclk, resetn, clkEn, strap0, strap1, mgmtStrap;
  logic [PMX_ADDR_W-1:0] regAddr;
  logic [PMX_DATA_W-1:0] regWdata, regRdata;
  logic                  regWr, regRd, refClkIn, refClkOut;
  logic                  colIn, colOut, colOeN, crsIn, crsOut, crsOeN;
  logic                  coreCol, coreCrs, seenCol, seenCrs;
  logic                  mdioIn, mdioOut, mdioOeN, mdcIn, mdcOut, mdcOeN;
  logic                  slvMdioOut, slvMdioOe, slvMdio, slvMdcRise;
  pmx_pad_s              refClkPad;
  int                    miscompares = 0;
  int                    nCompared = 0;
  int                    rises = 0;

  pmx_port0_pin_ctrl #(.REF_HALF(HALF)) dut (.mclk(mclk), .resetn(resetn), .clkEn(clkEn),
    .port0_mode_strap_bit0(strap0), .modeStrapBit1(strap1), .mgmtStrap(mgmtStrap),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .refClkIn(refClkIn), .refClkOut(refClkOut), .refClkPad(refClkPad), .colIn(colIn), .colOut(colOut),
    .colOeN(colOeN), .crsIn(crsIn), .crsOut(crsOut), .crsOeN(crsOeN), .coreCol(coreCol),
    .coreCrs(coreCrs), .seenCol(seenCol), .seenCrs(seenCrs), .mdioIn(mdioIn), .mdioOut(mdioOut),
    .mdioOeN(mdioOeN), .mdcIn(mdcIn), .mdcOut(mdcOut), .mdcOeN(mdcOeN), .slvMdioOut(slvMdioOut),
    .slvMdioOe(slvMdioOe), .slvMdio(slvMdio), .slvMdcRise(slvMdcRise));
  pmx_far_end far (.mdioOut(mdioOut), .mdioOeN(mdioOeN), .mdcOut(mdcOut), .mdcOeN(mdcOeN),
    .refClkOut(refClkOut), .refClkPad(refClkPad), .refClkIn(refClkIn), .colIn(colIn), .crsIn(crsIn),
    .mdioIn(mdioIn), .mdcIn(mdcIn));

  // ****************************************
  // helpers
  // ****************************************
  // clock generator
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // count slave clock edges seen by the device
  always @(posedge mclk) if (slvMdcRise === 1'b1) rises++;

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    nCompared++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask
  task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge mclk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask
  task automatic do_reset(input logic [1:0] mode, input logic mg);
    @(posedge mclk);
    resetn <= 1'b0;
    {strap1, strap0} <= mode;
    mgmtStrap <= mg;
    repeat (5) @(posedge mclk);
    check(8'({refClkPad, colOeN, crsOeN, mdioOeN, mdcOeN}), 8'hAF, "pads in reset");
    check(8'({mdioOut, slvMdio, refClkOut, colOut, seenCol, slvMdcRise}), 8'h30, "pins in reset");
    resetn <= 1'b1;
    repeat (2) @(posedge mclk);
  endtask
  // reference pad model {outEnN, inBufEn, pullDnEn, strongDrv}
  function automatic logic [3:0] exp_pad(logic [1:0] mode, logic iso, logic dir, logic str);
    if (mode == 2'h3 && iso) return 4'h8;
    if (mode[1] && dir) return {3'h0, str};
    if (mode[1]) return 4'hE;
    return 4'hA;
  endfunction

  // ****************************************
  // one strap setting
  // ****************************************
  task automatic run_mode(input logic [1:0] mode, input logic mg);
    logic [31:0] d;
    logic [3:0]  e;
    logic        cc, cs, prev;
    int          tog;
    do_reset(mode, mg);
    reg_read(PMX_REG_STATUS, d);
    check(d[7:0], {1'b1, mg, mode, 4'h0}, "strap status");
    @(posedge mclk);
    {strap1, strap0} <= ~mode;
    mgmtStrap <= ~mg;
    reg_write(4'h7, 32'hFFFF_FFFF);
    reg_read(4'h7, d);
    check(d[7:0], 8'h00, "unmapped");
    reg_read(PMX_REG_STATUS, d);
    check(d[7:4], {1'b1, mg, mode}, "strap held");
    for (int k = 0; k < 8; k++) begin
      reg_write(PMX_REG_BASIC, {21'h0, k[2], 10'h0});
      reg_write(PMX_REG_SPECIAL, {30'h0, k[1], k[0]});
      cc = 1'($urandom);
      cs = 1'($urandom);
      @(posedge mclk);
      coreCol <= cc;
      coreCrs <= cs;
      reg_read(PMX_REG_SPECIAL, d);
      check(d[7:0], {6'h0, k[1], k[0]}, "special readback");
      e = exp_pad(mode, k[2], k[0], k[1]);
      check(8'({refClkPad[3:1], e[3] ? 1'b0 : refClkPad[0]}), 8'(e), "ref pad");
      if (mode == 2'h1) check(8'({colOeN, crsOeN, colOut, crsOut}), 8'({k[2], k[2], cc, cs}), "drive");
      else check(8'({colOeN, crsOeN}), 8'h3, "col crs off");
      if (mode[1] && k[0] && !(mode == 2'h3 && k[2])) begin
        tog = 0;
        prev = refClkOut;
        repeat (40) begin
          @(posedge mclk);
          #1 tog += (refClkOut !== prev);
          prev = refClkOut;
        end
        check(8'(tog), 8'(40 / HALF), "ref toggles");
      end else if (!k[0]) check(8'(refClkOut), 8'h0, "ref quiet");
    end
    if (mode != 2'h1) far.set_line(1'b1, 1'b1);
    repeat (6) @(posedge mclk);
    reg_read(PMX_REG_STATUS, d);
    check(8'({seenCol, seenCrs, d[3:2]}), (mode == 2'h0) ? 8'hF : 8'h0, "seen lines");
    far.set_line(1'b0, 1'b0);
    if (mg) begin
      for (int k = 0; k < 8; k++) begin
        reg_write(PMX_REG_MGMT, {29'h0, k[2:0]});
        repeat (3) @(posedge mclk);
        #1 e = {k[0], ~k[1], k[2], 1'b0};
        check(8'({mdioOut, mdioOeN, mdcOut, mdcOeN, mdioIn}), 8'({e, k[1] ? k[0] : 1'b1}), "master");
      end
    end else begin
      @(posedge mclk);
      slvMdioOut <= 1'($urandom);
      slvMdioOe <= 1'b1;
      repeat (3) @(posedge mclk);
      #1 check(8'({mdioOut, mdioOeN, mdcOeN}), 8'({slvMdioOut, 2'h1}), "slave pins");
      @(posedge mclk);
      slvMdioOe <= 1'b0;
      rises = 0;
      far.frame(8);
      repeat (8) @(posedge mclk);
      #1 check(8'(rises), 8'h08, "slave clock edges");
      check(8'({slvMdio, mdioIn}), 8'h3, "idle line");
    end
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  task automatic wrap_up;
    $display("comparisons %0d, mismatches %0d", nCompared, miscompares);
    if (miscompares == 0 && nCompared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // watchdog
  initial begin
    #200000;
    miscompares++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    wrap_up;
  end
  initial begin
    logic [31:0] rd;
    {resetn, strap0, strap1, mgmtStrap, regWr, regRd, coreCol, coreCrs} = 8'h00;
    {slvMdioOut, slvMdioOe, regAddr, regWdata} = '0;
    clkEn = 1'b1;
    void'($urandom(77));
    for (int m = 0; m < 4; m++) run_mode(2'(m), 1'(m));
    run_mode(2'h0, 1'b1);
    // clock enable low: a write must not land
    @(posedge mclk);
    clkEn <= 1'b0;
    reg_write(PMX_REG_SPECIAL, 32'h0000_0000);
    @(posedge mclk);
    clkEn <= 1'b1;
    reg_read(PMX_REG_SPECIAL, rd);
    check(rd[7:0], 8'h03, "frozen write ignored");
    wrap_up;
  end
endmodule // pmx_port0_pin_ctrl_bench
`default_nettype wire
